/* wdt_top.sv */
// Watchdog timer with classic Wishbone register slave
`timescale 1ns/100ps
`default_nettype none
`include "wdt_params.svh"
module wdt_top
    import wdt_pkg::*;
(
    input  wire logic        clk_i,          // Clock, 25 MHz
    input  wire logic        rst_i,          // Sync reset, high
    input  wire logic        wb_cyc_i,       // Wishbone cycle
    input  wire logic        wb_stb_i,       // Wishbone strobe
    input  wire logic        wb_we_i,        // Wishbone write
    input  wire logic [3:0]  wb_sel_i,       // Wishbone byte select
    input  wire logic [`WDT_ADDR_W-1:0] wb_adr_i, // Wishbone byte address
    input  wire logic [31:0] wb_dat_i,       // Wishbone write data
    output logic      [31:0] wb_dat_o,       // Wishbone read data
    output logic             wb_ack_o,       // Wishbone ack
    input  wire logic        halt_i,         // HALT executed, pulse
    input  wire logic        hw_watchdog_i,  // Option: always active
    input  wire logic        halt_reset_option_i, // Option: reset on HALT
    input  wire logic        long_phase_i,   // Option: 4096-cycle phase
    output logic             reset_n_o,      // Reset pin, low active
    output logic             reset_busy_o    // Reset cycle running
);
    logic [7:0]               ctrl_q;
    logic [`WDT_PRESC_W-1:0]  presc_q;
    logic                     tick;
    logic                     req;
    logic                     wr_ctrl;
    logic                     active;
    logic                     expire;
    logic                     sw_reset;
    logic                     halt_reset;
    logic                     trigger;
    logic                     cause_q;
    logic                     busy;

    function automatic logic hit(input logic [`WDT_ADDR_W-1:0] a,
                                 input logic [`WDT_ADDR_W-1:0] b);
        hit = (a == b);
    endfunction : hit

    assign req     = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    assign wr_ctrl = req & wb_we_i & wb_sel_i[0] & hit(wb_adr_i, `WDT_ADDR_CTRL);

    // Free-running prescaler; never cleared by writes, hence one-tick spread
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            presc_q <= '0;
        end else if (presc_q == `WDT_PRESC_LAST) begin
            presc_q <= '0;
        end else begin
            presc_q <= presc_q + 1'b1;
        end
    end
    assign tick = (presc_q == `WDT_PRESC_LAST);

    assign active = ctrl_q[`WDT_BIT_ACT] | hw_watchdog_i;

    // Expiry when count passes 40h to 3Fh
    assign expire = active & tick & (ctrl_q[6:0] == `WDT_CNT_EXPIRE);
    assign sw_reset = wr_ctrl & (wb_dat_i[`WDT_BIT_ACT] | hw_watchdog_i)
                      & ~wb_dat_i[`WDT_BIT_MSB];
    assign halt_reset = active & halt_i & halt_reset_option_i;
    assign trigger = (expire | sw_reset | halt_reset) & ~busy;

    // Control register; reset deactivates, writes cannot deactivate
    always_ff @(posedge clk_i) begin
        if (rst_i || busy) begin
            ctrl_q <= `WDT_CTRL_RESET;
        end else if (wr_ctrl) begin
            ctrl_q[`WDT_BIT_ACT] <= ctrl_q[`WDT_BIT_ACT] | wb_dat_i[`WDT_BIT_ACT];
            ctrl_q[6:0]          <= wb_dat_i[6:0];
        end else if (tick) begin
            ctrl_q[6:0] <= ctrl_q[6:0] - 7'h01;
        end
    end

    // Last reset cause: watchdog-generated, survives chip reset cycle
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cause_q <= 1'b0;
        end else if (trigger) begin
            cause_q <= 1'b1;
        end else if (req & wb_we_i & wb_sel_i[0] & hit(wb_adr_i, `WDT_ADDR_STAT)
                     & wb_dat_i[0]) begin
            cause_q <= 1'b0;
        end
    end

    // Single-wait-state Wishbone answer
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= '0;
        end else begin
            wb_ack_o <= req;
            if (req & ~wb_we_i) begin
                if (hit(wb_adr_i, `WDT_ADDR_CTRL)) begin
                    wb_dat_o <= {24'h000000, ctrl_q};
                end else if (hit(wb_adr_i, `WDT_ADDR_STAT)) begin
                    wb_dat_o <= {30'h00000000, busy, cause_q};
                end else begin
                    wb_dat_o <= '0;
                end
            end
        end
    end

    wdt_reset_gen u_reset_gen (
        .clk_i        (clk_i),
        .rst_i        (rst_i),
        .trigger_i    (trigger),
        .long_phase_i (long_phase_i),
        .reset_n_o    (reset_n_o),
        .busy_o       (busy)
    );

    assign reset_busy_o = busy;
endmodule : wdt_top
`default_nettype wire

/* wdt_params.svh */
// Constants for the windowed-free watchdog timer
//
// Functional notes
// - Countdown decrements once every 16000 cycles; 64 programmable steps.
// - Active and count passes 40h to 3Fh: reset pin low ~30 us.
// - Countdown runs even when watchdog is not activated.
// - Reset deactivates; once activated, only a reset clears activation.
// - Write with activate set and msb clear gives immediate reset.
// - HALT while active resets only if option selects reset on HALT.
// - Hardware watchdog option: always active, activate bit ignored.
// - Control holds activate in bit 7, count in bits 6:0; resets 7Fh.
// - C0h gives 0-2 ms, FFh gives 126-128 ms at 8 MHz.
// - Reset phase adds 256 or 4096 CPU cycles before resuming.
`ifndef WDT_PARAMS_SVH
`define WDT_PARAMS_SVH

`define WDT_CLK_HZ          25000000
`define WDT_PRESC_TICKS     16000
`define WDT_PRESC_W         14
`define WDT_PRESC_LAST      14'h3E7F
`define WDT_PULSE_NS        30000
`define WDT_PULSE_CYC       ((`WDT_PULSE_NS * (`WDT_CLK_HZ / 1000000)) / 1000)
`define WDT_PULSE_W         10
`define WDT_PHASE_SHORT     256
`define WDT_PHASE_LONG      4096
`define WDT_PHASE_W         13
`define WDT_CTRL_RESET      8'h7F
`define WDT_BIT_ACT         7
`define WDT_BIT_MSB         6
`define WDT_CNT_EXPIRE      7'h40
`define WDT_ADDR_CTRL       4'h0
`define WDT_ADDR_STAT       4'h4
`define WDT_ADDR_W          4

`endif

/* wdt_pkg.sv */
// Types shared by the watchdog timer files
`default_nettype none
package wdt_pkg;
    typedef enum logic [1:0] {
        WDT_IDLE,
        WDT_PULSE,
        WDT_PHASE
    } wdt_state_t;
endpackage : wdt_pkg
`default_nettype wire

/* wdt_reset_gen.sv */
// Reset pulse and reset phase sequencer for the watchdog
`timescale 1ns/100ps
`default_nettype none
`include "wdt_params.svh"
module wdt_reset_gen
    import wdt_pkg::*;
(
    input  wire logic clk_i,         // Clock
    input  wire logic rst_i,         // Sync reset, high
    input  wire logic trigger_i,     // Start reset cycle
    input  wire logic long_phase_i,  // Use long reset phase
    output logic      reset_n_o,     // Reset pin drive, low active
    output logic      busy_o         // Reset cycle running
);
    wdt_state_t               state_q;
    logic [`WDT_PHASE_W-1:0]  cnt_q;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_q <= WDT_IDLE;
            cnt_q   <= '0;
        end else begin
            case (state_q)
                WDT_IDLE: begin
                    if (trigger_i) begin
                        state_q <= WDT_PULSE;
                        cnt_q   <= '0;
                    end
                end
                WDT_PULSE: begin
                    if (cnt_q == `WDT_PHASE_W'(`WDT_PULSE_CYC - 1)) begin
                        state_q <= WDT_PHASE;
                        cnt_q   <= '0;
                    end else begin
                        cnt_q <= cnt_q + 1'b1;
                    end
                end
                WDT_PHASE: begin
                    // Extra start-up cycles before the core resumes
                    if (cnt_q == (long_phase_i ? `WDT_PHASE_W'(`WDT_PHASE_LONG - 1)
                                               : `WDT_PHASE_W'(`WDT_PHASE_SHORT - 1))) begin
                        state_q <= WDT_IDLE;
                        cnt_q   <= '0;
                    end else begin
                        cnt_q <= cnt_q + 1'b1;
                    end
                end
                default: state_q <= WDT_IDLE;
            endcase
        end
    end

    assign reset_n_o = (state_q != WDT_PULSE);
    assign busy_o    = (state_q != WDT_IDLE);
endmodule : wdt_reset_gen
`default_nettype wire

/* wdt_properties.sv */
// Bus and reset timing checker
`timescale 1ns/100ps
`default_nettype none
module wdt_properties (
    input wire logic clk_i,        // Clock
    input wire logic rst_i,        // Reset
    input wire logic wb_stb_i,     // Strobe
    input wire logic wb_ack_o,     // Ack
    input wire logic long_phase_i, // Long phase
    input wire logic reset_n_o,    // Reset pin
    input wire logic reset_busy_o  // Busy
);
    logic [12:0] low_q, ph_q;
    always_ff @(posedge clk_i) low_q <= reset_n_o ? 13'h0 : low_q + 13'h1;
    always_ff @(posedge clk_i) ph_q <= (reset_busy_o && reset_n_o) ? ph_q + 13'h1 : 13'h0;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    ack_next_a: assert property (wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("no ack");
    ack_once_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack long");
    ack_cause_a: assert property (wb_ack_o |-> $past(wb_stb_i)) else $error("stray ack");
    pulse_len_a: assert property ($rose(reset_n_o) |-> low_q == 13'h2EE) else $error("pulse");
    phase_len_a: assert property ($fell(reset_busy_o) |->
        ph_q == (long_phase_i ? 13'h1000 : 13'h100)) else $error("phase");
    low_busy_a: assert property (!reset_n_o |-> reset_busy_o) else $error("low idle");
    start_low_a: assert property ($rose(reset_busy_o) |-> !reset_n_o) else $error("start");
    phase_on_a: assert property ($rose(reset_n_o) |-> reset_busy_o) else $error("no phase");
endmodule : wdt_properties
bind wdt_top wdt_properties u_props (.clk_i, .rst_i, .wb_stb_i, .wb_ack_o, .long_phase_i,
    .reset_n_o, .reset_busy_o);
`default_nettype wire

/* tb_top.sv */
// Self-checking bench for the watchdog timer
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    logic        clk_i, rst_i, cyc, stb, we, halt, hw, hro, lp, ack, rn, busy;
    logic [3:0]  sel, adr;
    logic [31:0] wd, rdat;
    int          err_count = 0, n_compared = 0, seed = 49, cn = 0, nl = 0, nb = 0, v;
    wdt_top uut (.clk_i, .rst_i, .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_sel_i(sel),
        .wb_adr_i(adr), .wb_dat_i(wd), .wb_dat_o(rdat), .wb_ack_o(ack), .halt_i(halt),
        .hw_watchdog_i(hw), .halt_reset_option_i(hro), .long_phase_i(lp), .reset_n_o(rn),
        .reset_busy_o(busy));
    initial forever #20 clk_i = ~clk_i;
    always @(posedge clk_i) cn <= rst_i ? 0 : cn + 1;
    always @(posedge clk_i) if (busy === 1'b1) {nl, nb} <= {nl + (rn === 1'b0), nb + 1};
    task automatic chk(input string s, input logic [31:0] e, g);
        n_compared++;
        if (g !== e) $display("BAD %s expected %h seen %h", s, e, g);
        if (g !== e) err_count++;
    endtask : chk
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
        {cyc, stb, we, sel, adr, wd} <= {2'b11, w, 4'hF, a, d};
        @(posedge clk_i);
        while (ack !== 1'b1) @(posedge clk_i);
        if (!w) chk("read", d, rdat);
        {cyc, stb} <= 2'b00;
        @(posedge clk_i);
    endtask : bus
    task automatic rcy(input int ph);
        while (busy !== 1'b1) @(posedge clk_i);
        while (busy === 1'b1) @(posedge clk_i);
        chk("low", 750, nl);
        chk("busy", 750 + ph, nb);
        {nl, nb} = 64'h0;
    endtask : rcy
    task automatic final_report;
        $display("Compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : final_report
    initial begin
        #2000000;
        err_count++;
        final_report;
    end
    initial begin
        {clk_i, rst_i, cyc, stb, we, halt, hw, hro, lp, sel, adr, wd} = {9'h080, 40'h0};
        v = 64 + ($random(seed) & 63);
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        bus(1'b0, 4'h0, 32'h7F);
        bus(1'b1, 4'h0, v);
        repeat (16000) @(posedge clk_i);
        bus(1'b0, 4'h0, v - 1);
        bus(1'b0, 4'h8, 32'h0);
        bus(1'b1, 4'h0, 32'hC0);
        while (busy !== 1'b1) @(posedge clk_i);
        chk("tick", 1, cn >= 32000 && cn < 32004);
        rcy(256);
        bus(1'b0, 4'h4, 32'h1);
        bus(1'b1, 4'h4, 32'h1);
        bus(1'b0, 4'h4, 32'h0);
        lp <= 1'b1;
        bus(1'b1, 4'h0, 32'hFF);
        bus(1'b1, 4'h0, 32'h7F);
        bus(1'b0, 4'h0, 32'hFF);
        halt <= 1'b1;
        @(posedge clk_i);
        halt <= 1'b0;
        repeat (3) @(posedge clk_i);
        chk("halt", 0, busy);
        {hro, halt} <= 2'b11;
        @(posedge clk_i);
        halt <= 1'b0;
        rcy(4096);
        {hw, lp} <= 2'b10;
        bus(1'b1, 4'h0, 32'h40);
        rcy(256);
        final_report;
    end
endmodule : tb_top
`default_nettype wire
